// ### rtl/adc_start_regs.svh
// Register offsets, field positions and reset values of the conversion start control
`ifndef ADC_START_REGS_SVH
`define ADC_START_REGS_SVH

// Byte addresses on the register bus
`define ADC_CTRL_OFS 4'h0
`define ADC_CFG_OFS 4'h4
`define ADC_RESULT_OFS 4'h8
`define ADC_STATUS_OFS 4'hC

// Control register fields
`define CTRL_BUSY_BIT 0
`define CTRL_DONE_BIT 1
`define CTRL_IE_BIT 2
`define CTRL_EN_BIT 3
`define CTRL_SEL_LSB 4
`define CTRL_SEL_MSB 6

// Configuration register fields
`define CFG_DIV_LSB 0
`define CFG_DIV_MSB 4
`define CFG_BURST_BIT 8
`define CFG_T2_WIDE_BIT 9
`define CFG_T3_WIDE_BIT 10

// Reset values
`define CTRL_RESET 32'h0000_0000
`define CFG_RESET 32'h0000_001F
`define DIV_RESET 5'h1F
`define SEL_RESET 3'h0

// Widths
`define DIV_W 5
`define RESULT_W 16

`endif

// ### rtl/adc_start_pkg.sv
// Types shared by the conversion start control files
package adc_start_pkg;

  // Start of conversion source codes
  typedef enum logic [2:0] {
    START_SOFTWARE = 3'h0,
    START_TIMER0 = 3'h1,
    START_TIMER2 = 3'h2,
    START_TIMER3 = 3'h3,
    START_EXTERNAL = 3'h4,
    START_RSVD5 = 3'h5,
    START_RSVD6 = 3'h6,
    START_RSVD7 = 3'h7
  } start_source_e;

  // Conversion sequencer states
  typedef enum logic [0:0] {
    SEQ_IDLE = 1'b0,
    SEQ_CONVERT = 1'b1
  } seq_state_e;

endpackage

// ### rtl/conv_clock_divider.sv
// Converter clock enable divider fed by a selectable source tick
`timescale 1ns/10ps
`include "adc_start_regs.svh"

module conv_clock_divider (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // Source tick and ratio
  input wire logic src_tick_i,
  input wire logic [`DIV_W-1:0] div_i,
  // Divided enable pulse
  output logic tick_o
);

  logic [`DIV_W-1:0] count_q;
  logic [`DIV_W-1:0] count_d;
  logic tick_q;
  logic tick_d;

  // Divide by div_i + 1 source ticks
  always_comb begin
    count_d = count_q;
    tick_d = 1'b0;
    if (src_tick_i) begin
      if (count_q >= div_i) begin
        count_d = '0;
        tick_d = 1'b1;
      end else begin
        count_d = count_q + `DIV_W'(1);
      end
    end
  end

  // Register divider state
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      count_q <= '0;
      tick_q <= 1'b0;
    end else begin
      count_q <= count_d;
      tick_q <= tick_d;
    end
  end

  assign tick_o = tick_q;

endmodule

// ### rtl/sar_adc_conversion_start_control.sv
// Start of conversion control and sequencing for the SAR converter
//
// Summary of operation
// - The converter clock divides the system clock without burst mode and the low-power oscillator with it.
// - The division ratio comes from the converter clock divider field of the configuration register.
// - One of five start sources is used, chosen by the 3-bit start select field; reserved codes 5 to 7 use none.
// - In software mode, writing 1 to the conversion-in-progress bit starts one conversion.
// - The conversion-in-progress bit reads 1 during a conversion and 0 once it completes.
// - When conversion-in-progress falls the done flag sets and, if enabled, the interrupt rises.
// - The result registers hold the valid result whenever the done flag reads 1.
// - Timer 0, Timer 2 and Timer 3 overflows each start one conversion per overflow.
// - Timer 2 and 3 use low-byte overflow in 8-bit mode and high-byte overflow in 16-bit mode.
// - With the external source, each rising edge of the external start input begins one conversion.
// - The sequencing allows up to 300 ksps in 10-bit mode.
`timescale 1ns/10ps
`include "adc_start_regs.svh"

module sar_adc_conversion_start_control (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // Avalon-MM slave
  input wire logic [3:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // Timer overflow pulses, system clock domain
  input wire logic timer0_ovf_i,
  input wire logic timer2_low_ovf_i,
  input wire logic timer2_high_ovf_i,
  input wire logic timer3_low_ovf_i,
  input wire logic timer3_high_ovf_i,
  // Asynchronous pins
  input wire logic external_convert_start_i,
  input wire logic low_power_osc_i,
  // Converter core
  output logic converter_clock_o,
  output logic sar_start_o,
  input wire logic sar_done_i,
  input wire logic [`RESULT_W-1:0] sar_data_i,
  // Completion interrupt
  output logic adc_irq_o
);

  // Control fields
  logic done_q;
  logic done_d;
  logic irq_en_q;
  logic irq_en_d;
  logic adc_en_q;
  logic adc_en_d;
  logic [2:0] start_sel_q;
  logic [2:0] start_sel_d;
  // Configuration fields
  logic [`DIV_W-1:0] clk_div_q;
  logic [`DIV_W-1:0] clk_div_d;
  logic burst_mode_enable_q;
  logic burst_mode_enable_d;
  logic t2_wide_q;
  logic t2_wide_d;
  logic t3_wide_q;
  logic t3_wide_d;
  // Result and sequencer
  logic [`RESULT_W-1:0] result_q;
  logic [`RESULT_W-1:0] result_d;
  adc_start_pkg::seq_state_e state_q;
  adc_start_pkg::seq_state_e state_d;
  logic sar_start_q;
  logic sar_start_d;
  logic overrun_q;
  logic overrun_d;
  // Bus slave
  logic ack_q;
  logic ack_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  // Pin synchronisers
  logic [2:0] ext_sync_q;
  logic [2:0] lpo_sync_q;
  logic ext_rise;
  logic lpo_rise;
  // Trigger decode
  logic trigger;
  logic sw_start;
  logic bus_take;
  logic wr_ctrl;
  logic wr_cfg;
  logic src_tick;
  logic conv_tick;
  logic conv_clk_q;
  logic busy;

  // A request is served on its second cycle; readdata is prepared on the first
  assign bus_take = (avs_read_i | avs_write_i) & ~ack_q;
  assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~ack_q;
  assign wr_ctrl = avs_write_i & ~ack_q & (avs_address_i == `ADC_CTRL_OFS) & avs_byteenable_i[0];
  assign wr_cfg = avs_write_i & ~ack_q & (avs_address_i == `ADC_CFG_OFS);

  assign busy = (state_q == adc_start_pkg::SEQ_CONVERT);

  // Two flops before any logic looks at the pins; third flop only for edges
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      ext_sync_q <= 3'h0;
      lpo_sync_q <= 3'h0;
    end else begin
      ext_sync_q <= {ext_sync_q[1:0], external_convert_start_i};
      lpo_sync_q <= {lpo_sync_q[1:0], low_power_osc_i};
    end
  end

  // Edge detects read only the settled stages
  assign ext_rise = ext_sync_q[1] & ~ext_sync_q[2];
  assign lpo_rise = lpo_sync_q[1] & ~lpo_sync_q[2];

  // Divider source: every system cycle or each rising oscillator edge
  assign src_tick = burst_mode_enable_q ? lpo_rise : 1'b1;

  conv_clock_divider u_div (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .src_tick_i(src_tick),
    .div_i(clk_div_q),
    .tick_o(conv_tick)
  );

  // Software start only counts in software mode
  assign sw_start = wr_ctrl & avs_writedata_i[`CTRL_BUSY_BIT]
                    & (start_sel_d == adc_start_pkg::START_SOFTWARE);

  // One source only; reserved codes never start anything
  always_comb begin
    trigger = 1'b0;
    unique case (adc_start_pkg::start_source_e'(start_sel_q))
      adc_start_pkg::START_SOFTWARE: trigger = sw_start;
      adc_start_pkg::START_TIMER0: trigger = timer0_ovf_i;
      adc_start_pkg::START_TIMER2: trigger = t2_wide_q ? timer2_high_ovf_i
                                                       : timer2_low_ovf_i;
      adc_start_pkg::START_TIMER3: trigger = t3_wide_q ? timer3_high_ovf_i
                                                       : timer3_low_ovf_i;
      adc_start_pkg::START_EXTERNAL: trigger = ext_rise;
      adc_start_pkg::START_RSVD5,
      adc_start_pkg::START_RSVD6,
      adc_start_pkg::START_RSVD7: trigger = 1'b0;
    endcase
  end

  // Register fields, with hardware set of done winning over a clear
  always_comb begin
    irq_en_d = irq_en_q;
    adc_en_d = adc_en_q;
    start_sel_d = start_sel_q;
    clk_div_d = clk_div_q;
    burst_mode_enable_d = burst_mode_enable_q;
    t2_wide_d = t2_wide_q;
    t3_wide_d = t3_wide_q;
    done_d = done_q;
    if (wr_ctrl) begin
      irq_en_d = avs_writedata_i[`CTRL_IE_BIT];
      adc_en_d = avs_writedata_i[`CTRL_EN_BIT];
      start_sel_d = avs_writedata_i[`CTRL_SEL_MSB:`CTRL_SEL_LSB];
      if (avs_writedata_i[`CTRL_DONE_BIT]) begin
        done_d = 1'b0;
      end
    end
    if (wr_cfg && avs_byteenable_i[0]) begin
      clk_div_d = avs_writedata_i[`CFG_DIV_MSB:`CFG_DIV_LSB];
    end
    if (wr_cfg && avs_byteenable_i[1]) begin
      burst_mode_enable_d = avs_writedata_i[`CFG_BURST_BIT];
      t2_wide_d = avs_writedata_i[`CFG_T2_WIDE_BIT];
      t3_wide_d = avs_writedata_i[`CFG_T3_WIDE_BIT];
    end
    if (busy && sar_done_i) begin
      done_d = 1'b1;
    end
  end

  // Sequencer: idle, then one conversion until the core reports done
  always_comb begin
    state_d = state_q;
    result_d = result_q;
    sar_start_d = 1'b0;
    overrun_d = overrun_q;
    unique case (state_q)
      adc_start_pkg::SEQ_IDLE: begin
        if (trigger && adc_en_q) begin
          state_d = adc_start_pkg::SEQ_CONVERT;
          sar_start_d = 1'b1;
        end
      end
      adc_start_pkg::SEQ_CONVERT: begin
        // Late triggers are dropped but remembered for software
        if (trigger) begin
          overrun_d = 1'b1;
        end
        if (sar_done_i) begin
          // Result lands in the same edge that sets done
          result_d = sar_data_i;
          state_d = adc_start_pkg::SEQ_IDLE;
        end
      end
    endcase
    if (wr_ctrl && avs_writedata_i[`CTRL_DONE_BIT]) begin
      overrun_d = 1'b0;
    end
  end

  // Converter clock toggles on each divided tick, so it runs at half the tick rate
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      conv_clk_q <= 1'b0;
    end else if (conv_tick) begin
      conv_clk_q <= ~conv_clk_q;
    end
  end

  // Read mux, unmapped addresses read zero
  always_comb begin
    rdata_d = rdata_q;
    ack_d = bus_take;
    if (bus_take && avs_read_i) begin
      rdata_d = 32'h0000_0000;
      unique case (avs_address_i)
        `ADC_CTRL_OFS: begin
          rdata_d[`CTRL_BUSY_BIT] = busy;
          rdata_d[`CTRL_DONE_BIT] = done_q;
          rdata_d[`CTRL_IE_BIT] = irq_en_q;
          rdata_d[`CTRL_EN_BIT] = adc_en_q;
          rdata_d[`CTRL_SEL_MSB:`CTRL_SEL_LSB] = start_sel_q;
        end
        `ADC_CFG_OFS: begin
          rdata_d[`CFG_DIV_MSB:`CFG_DIV_LSB] = clk_div_q;
          rdata_d[`CFG_BURST_BIT] = burst_mode_enable_q;
          rdata_d[`CFG_T2_WIDE_BIT] = t2_wide_q;
          rdata_d[`CFG_T3_WIDE_BIT] = t3_wide_q;
        end
        `ADC_RESULT_OFS: rdata_d[`RESULT_W-1:0] = result_q;
        `ADC_STATUS_OFS: rdata_d[1:0] = {overrun_q, busy};
        default: rdata_d = 32'h0000_0000;
      endcase
    end
  end

  // Register all state
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      done_q <= 1'b0;
      irq_en_q <= 1'b0;
      adc_en_q <= 1'b0;
      start_sel_q <= `SEL_RESET;
      clk_div_q <= `DIV_RESET;
      burst_mode_enable_q <= 1'b0;
      t2_wide_q <= 1'b0;
      t3_wide_q <= 1'b0;
      result_q <= '0;
      state_q <= adc_start_pkg::SEQ_IDLE;
      sar_start_q <= 1'b0;
      overrun_q <= 1'b0;
      ack_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end else begin
      done_q <= done_d;
      irq_en_q <= irq_en_d;
      adc_en_q <= adc_en_d;
      start_sel_q <= start_sel_d;
      clk_div_q <= clk_div_d;
      burst_mode_enable_q <= burst_mode_enable_d;
      t2_wide_q <= t2_wide_d;
      t3_wide_q <= t3_wide_d;
      result_q <= result_d;
      state_q <= state_d;
      sar_start_q <= sar_start_d;
      overrun_q <= overrun_d;
      ack_q <= ack_d;
      rdata_q <= rdata_d;
    end
  end

  // Outputs
  assign avs_readdata_o = rdata_q;
  assign converter_clock_o = conv_clk_q;
  assign sar_start_o = sar_start_q;
  assign adc_irq_o = done_q & irq_en_q;

endmodule

// ### testbench/sar_adc_conversion_start_control_properties.sv
// Port-level properties of the conversion start control
`timescale 1ns/10ps
`include "adc_start_regs.svh"
module adc_start_props (
  // Clock, reset and bus
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic [3:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic avs_waitrequest_o,
  // Trigger, core and interrupt
  input wire logic timer0_ovf_i,
  input wire logic sar_start_o,
  input wire logic sar_done_i,
  input wire logic [`RESULT_W-1:0] sar_data_i,
  input wire logic adc_irq_o
);
  logic busy_q, busy_d, wr_ctl;
  logic [7:0] ctl_q, ctl_d;
  logic [`RESULT_W-1:0] res_q, res_d;
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  // Shadow control byte, span of a conversion, last result
  assign wr_ctl = avs_write_i && avs_waitrequest_o && avs_address_i == 4'h0 && avs_byteenable_i[0];
  always_comb begin
    busy_d = sar_start_o ? 1'b1 : (sar_done_i ? 1'b0 : busy_q);
    ctl_d = wr_ctl ? avs_writedata_i[7:0] : ctl_q;
    res_d = (busy_q && sar_done_i) ? sar_data_i : res_q;
  end
  // Shadow starts with the design's reset values
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      busy_q <= 1'b0;
      ctl_q <= 8'h00;
      res_q <= '0;
    end else begin
      busy_q <= busy_d;
      ctl_q <= ctl_d;
      res_q <= res_d;
    end
  end
  a_start_single: assert property (sar_start_o |=> !sar_start_o)
    else $error("start pulse longer than one cycle");
  a_start_idle: assert property (sar_start_o |-> !busy_q)
    else $error("start while a conversion runs");
  a_start_code: assert property (sar_start_o |-> $past(ctl_q[6:4]) < 3'h5 && $past(ctl_q[3]))
    else $error("start from reserved code or disabled");
  a_timer0_start: assert property (!busy_q && !sar_start_o && !sar_done_i && !avs_write_i
    && ctl_q[3] && ctl_q[6:4] == 3'h1 && timer0_ovf_i |=> sar_start_o)
    else $error("timer 0 overflow did not start");
  a_bus_answer: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o
    |=> !avs_waitrequest_o)
    else $error("bus answer late");
  a_irq_on_done: assert property (busy_q && sar_done_i && ctl_q[2] && !avs_write_i
    |=> adc_irq_o)
    else $error("no interrupt after completion");
  a_irq_needs_ie: assert property (adc_irq_o |-> ctl_q[2])
    else $error("interrupt while disabled");
  a_done_holds: assert property (adc_irq_o && !avs_write_i |=> adc_irq_o)
    else $error("done dropped without clear");
  a_result_read: assert property (avs_read_i && !avs_waitrequest_o && avs_address_i == 4'h8
    |-> avs_readdata_o[`RESULT_W-1:0] == res_q)
    else $error("result read differs");
  c_start: cover property (sar_start_o);
  c_done: cover property (busy_q && sar_done_i);
  c_irq: cover property (adc_irq_o);
endmodule

bind sar_adc_conversion_start_control adc_start_props u_props (
  .clk_sys_i(clk_sys_i), .rst_i(rst_i), .avs_address_i(avs_address_i),
  .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
  .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
  .avs_waitrequest_o(avs_waitrequest_o), .timer0_ovf_i(timer0_ovf_i),
  .sar_start_o(sar_start_o), .sar_done_i(sar_done_i), .sar_data_i(sar_data_i),
  .adc_irq_o(adc_irq_o)
);

// ### testbench/test_sar_adc_conversion_start_control.sv
// Self-checking bench for the conversion start control
`timescale 1ns/10ps
`include "adc_start_regs.svh"
module test_sar_adc_conversion_start_control;
  logic clk_sys_i = 0, rst_i = 1, rd = 0, wr = 0, done = 0, lpo = 0, cprev = 0;
  logic [3:0] adr = 4'h0;
  logic [31:0] wd = 32'h0, rdo, rdata;
  logic wait_o, cclk, start, irq;
  logic [6:1] trg = 6'h00;
  logic [15:0] sdat = 16'h0000;
  int errors = 0, checks_done = 0, starts = 0, ticks = 0, cyc = 0, n;
  // Row table: select, timer width bits, source fired, starts expected
  int stab[14] = '{0, 1, 2, 2, 2, 2, 3, 3, 3, 4, 4, 5, 6, 7};
  int wtab[14] = '{0, 0, 0, 0, 2, 2, 0, 4, 4, 0, 0, 0, 0, 0};
  int ftab[14] = '{0, 1, 2, 3, 3, 2, 4, 5, 4, 6, 1, 1, 6, 0};
  int etab[14] = '{1, 1, 1, 0, 1, 0, 1, 1, 0, 1, 0, 0, 0, 0};
  always #5 clk_sys_i = ~clk_sys_i;
  // Slow oscillator, one rising edge per eight system cycles
  always #40 lpo = ~lpo;
  sar_adc_conversion_start_control DUT (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .avs_address_i(adr), .avs_read_i(rd),
    .avs_write_i(wr), .avs_writedata_i(wd), .avs_byteenable_i(4'hF),
    .avs_readdata_o(rdo), .avs_waitrequest_o(wait_o), .timer0_ovf_i(trg[1]),
    .timer2_low_ovf_i(trg[2]), .timer2_high_ovf_i(trg[3]), .timer3_low_ovf_i(trg[4]),
    .timer3_high_ovf_i(trg[5]), .external_convert_start_i(trg[6]), .low_power_osc_i(lpo),
    .converter_clock_o(cclk), .sar_start_o(start), .sar_done_i(done), .sar_data_i(sdat),
    .adc_irq_o(irq)
  );
  // Count starts and clock toggles; cut a hang short
  always @(posedge clk_sys_i) begin
    starts <= starts + int'(start);
    cprev <= cclk;
    ticks <= ticks + int'(cclk !== cprev);
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      errors++;
      stop_test();
    end
  end
  task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      errors++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  // One bus access, held until waitrequest is seen low
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys_i);
    adr <= a;
    wd <= d;
    wr <= w;
    rd <= !w;
    // Sample waitrequest and readdata only at rising edges
    do @(posedge clk_sys_i); while (wait_o !== 1'b0);
    rdata = rdo;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask
  task automatic fire(input int s);
    if (s == 0) bus(1'b1, `ADC_CTRL_OFS, 32'h0000_000D);
    else begin
      @(posedge clk_sys_i);
      trg[s] <= 1'b1;
      @(posedge clk_sys_i);
      trg <= 6'h00;
    end
  endtask
  task automatic stop_test;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    bus(1'b0, `ADC_CTRL_OFS, 32'h0);
    check("ctrl reset", `CTRL_RESET, rdata);
    bus(1'b0, `ADC_CFG_OFS, 32'h0);
    check("cfg reset", `CFG_RESET, rdata);
    bus(1'b1, 4'h2, 32'hFFFF_FFFF);
    bus(1'b0, 4'h2, 32'h0);
    check("unmapped", 32'h0, rdata);
    // Ratio 2 on the system clock, then ratio 1 on the oscillator
    bus(1'b1, `ADC_CFG_OFS, 32'h0000_0001);
    repeat (8) @(posedge clk_sys_i);
    n = ticks;
    repeat (80) @(posedge clk_sys_i);
    check("sys toggles", 32'h1, 32'(ticks - n inside {[39:41]}));
    bus(1'b1, `ADC_CFG_OFS, 32'h0000_0100);
    repeat (20) @(posedge clk_sys_i);
    n = ticks;
    repeat (80) @(posedge clk_sys_i);
    check("burst toggles", 32'h1, 32'(ticks - n inside {[9:11]}));
    for (int i = 0; i < 14; i++) begin
      bus(1'b1, `ADC_CFG_OFS, 32'h0000_001F | 32'(wtab[i] << 8));
      bus(1'b1, `ADC_CTRL_OFS, {25'h0, 3'(stab[i]), 4'hE});
      n = starts;
      fire(ftab[i]);
      repeat (8) @(posedge clk_sys_i);
      check("starts", 32'(etab[i]), 32'(starts - n));
      if (etab[i] == 1) begin
        bus(1'b0, `ADC_STATUS_OFS, 32'h0);
        check("busy", 32'h1, rdata);
        fire(ftab[i]);
        repeat (8) @(posedge clk_sys_i);
        check("ignored", 32'(n + 1), 32'(starts));
        bus(1'b0, `ADC_STATUS_OFS, 32'h0);
        check("overrun", 32'h3, rdata);
        @(posedge clk_sys_i);
        done <= 1'b1;
        sdat <= 16'h5A00 + 16'(i);
        @(posedge clk_sys_i);
        done <= 1'b0;
        sdat <= ~sdat;
        @(negedge clk_sys_i);
        check("irq", 32'h1, 32'(irq));
        repeat (20) @(posedge clk_sys_i);
        bus(1'b0, `ADC_CTRL_OFS, 32'h0);
        check("ctrl done", {25'h0, 3'(stab[i]), 4'hE}, rdata);
        bus(1'b0, `ADC_RESULT_OFS, 32'h0);
        check("result", 32'h5A00 + 32'(i), rdata);
        bus(1'b1, `ADC_CTRL_OFS, 32'h0000_0002);
        check("irq clear", 32'h0, 32'(irq));
        bus(1'b0, `ADC_STATUS_OFS, 32'h0);
        check("status", 32'h0, rdata);
      end
    end
    stop_test();
  end
endmodule
